// ---- verilog/qtm_pkg.sv ----
// Package of constants and carrier types for the quad timer block
package qtm_pkg;
    localparam int QTM_NTIM = 4;
    localparam int QTM_AW   = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] QTM_IDX_DAT_LO [QTM_NTIM] = '{8'h68, 8'h6a, 8'h76, 8'h78};
    localparam logic [7:0] QTM_IDX_DAT_HI [QTM_NTIM] = '{8'h69, 8'h6b, 8'h77, 8'h79};
    localparam logic [7:0] QTM_IDX_CNT_LO [QTM_NTIM] = '{8'h6c, 8'h6e, 8'h7a, 8'h7c};
    localparam logic [7:0] QTM_IDX_CNT_HI [QTM_NTIM] = '{8'h6d, 8'h6f, 8'h7b, 8'h7d};
    localparam logic [7:0] QTM_IDX_CON0   [QTM_NTIM] = '{8'h70, 8'h72, 8'h7e, 8'h80};
    localparam logic [7:0] QTM_IDX_CON1   [QTM_NTIM] = '{8'h71, 8'h73, 8'h7f, 8'h81};
    localparam logic [7:0] QTM_IDX_STAT   [QTM_NTIM] = '{8'h74, 8'h75, 8'h82, 8'h83};
    localparam logic [7:0] QTM_IDX_IRQ_STS = 8'h90;
    localparam logic [7:0] QTM_IDX_IRQ_MSK = 8'h91;
    // Implemented mode bits per timer
    localparam logic [2:0] QTM_CON0_MASK [QTM_NTIM] = '{3'h7, 3'h3, 3'h5, 3'h1};
    localparam int QTM_RUN_BIT = 0;
    localparam int QTM_FM_BIT  = 2;
    localparam int QTM_OVF_BIT = 0;
    localparam logic [2:0] QTM_T0_AR_RUN  = 3'h1;
    localparam logic [2:0] QTM_T0_CAP_RUN = 3'h3;
    localparam logic [2:0] QTM_T0_FMEAS   = 3'h4;
    localparam logic [1:0] QTM_CLK_LOW     = 2'h0;
    localparam logic [1:0] QTM_CLK_HIGH    = 2'h1;
    localparam logic [1:0] QTM_CLK_EXT     = 2'h2;
    localparam logic [1:0] QTM_CLK_PARTNER = 2'h3;
    // Reset values and counter maximum
    localparam logic [2:0] QTM_CON0_RST = 3'h0;
    localparam logic [1:0] QTM_CON1_RST = 2'h0;
    localparam logic [7:0] QTM_CNT_RST  = 8'h00;
    localparam logic [3:0] QTM_IRQ_RST  = 4'h0;
    localparam logic [7:0] QTM_CNT_MAX  = 8'hff;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] clk_sel;
    } qtm_ctrl_t;

    typedef struct packed {
        logic [1:0] cnt_we;
        logic [1:0] dat_we;
        logic [3:0] wdata;
    } qtm_wr_t;

    typedef enum logic {QTM_BUS_IDLE, QTM_BUS_DATA} qtm_bus_st_t;
endpackage

// ---- verilog/qtm_pin_sync.sv ----
// Three-stage synchroniser with rising-edge detection for clock pins
`timescale 1ns/1ps
module qtm_pin_sync #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    // Pins and edge pulses
    input  wire logic [N-1:0] i_pin,
    output logic      [N-1:0] o_rise
);
    logic [N-1:0] s1_reg;
    logic [N-1:0] s2_reg;
    logic [N-1:0] s3_reg;
    logic [N-1:0] lvl_reg;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    s1_reg[g]  <= 1'b0;
                    s2_reg[g]  <= 1'b0;
                    s3_reg[g]  <= 1'b0;
                    lvl_reg[g] <= 1'b0;
                end else begin
                    s1_reg[g] <= i_pin[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        lvl_reg[g] <= s3_reg[g];
                    end
                end
            end
            // Accepted level rises only once two stages agree
            assign o_rise[g] = (s2_reg[g] == s3_reg[g]) && s3_reg[g] && !lvl_reg[g];
        end
    endgenerate
endmodule

// ---- verilog/qtm_timer_chan.sv ----
// One 8-bit up-counter with reload data register and overflow flag
`timescale 1ns/1ps
module qtm_timer_chan
    import qtm_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // Count event and software writes
    input  wire logic       i_tick,
    input  wire qtm_wr_t    i_wr,
    // State
    output logic [7:0]      o_count,
    output logic [7:0]      o_data,
    output logic            o_ovf,
    output logic            o_ovf_flag
);
    logic [7:0] cnt_reg;
    logic [7:0] dat_reg;
    logic       flag_reg;

    assign o_ovf = i_tick && (cnt_reg == QTM_CNT_MAX) && (i_wr.cnt_we == 2'h0);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= QTM_CNT_RST;
        end else if (i_wr.cnt_we != 2'h0) begin
            if (i_wr.cnt_we[0]) cnt_reg[3:0] <= i_wr.wdata;
            if (i_wr.cnt_we[1]) cnt_reg[7:4] <= i_wr.wdata;
        end else if (o_ovf) begin
            cnt_reg <= dat_reg;
        end else if (i_tick) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dat_reg <= QTM_CNT_RST;
        end else begin
            if (i_wr.cnt_we[0] || i_wr.dat_we[0]) dat_reg[3:0] <= i_wr.wdata;
            if (i_wr.cnt_we[1] || i_wr.dat_we[1]) dat_reg[7:4] <= i_wr.wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flag_reg <= 1'b0;
        end else if (o_ovf) begin
            flag_reg <= !flag_reg;
        end
    end

    assign o_count    = cnt_reg;
    assign o_data     = dat_reg;
    assign o_ovf_flag = flag_reg;
endmodule

// ---- verilog/qtm_top.sv ----
// Quad 8-bit timer with mode and clock selection behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module qtm_top
    import qtm_pkg::*;
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Timer clock sources
    input  wire logic        i_low_speed_base_clock,
    input  wire logic        i_high_speed_osc_clock,
    input  wire logic        i_ext_clock_pin_a,
    input  wire logic        i_ext_clock_pin_b,
    // Status and interrupt
    output logic      [3:0]  o_ovf_toggle,
    output logic             o_irq
);
    qtm_bus_st_t     st_reg;
    logic            hready_reg;
    logic [31:0]     hrdata_reg;
    logic            aw_reg;
    logic            amap_reg;
    logic [7:0]      aidx_reg;
    logic            wr_hit;
    logic            rd_hit;
    logic [31:0]     rd_mux;
    qtm_ctrl_t       ctrl_reg [QTM_NTIM];
    qtm_wr_t         wr       [QTM_NTIM];
    logic [7:0]      count    [QTM_NTIM];
    logic [7:0]      data     [QTM_NTIM];
    logic [3:0]      ovf;
    logic [3:0]      flag;
    logic [3:0]      tick;
    logic [3:0]      en;
    logic [3:0]      rise;
    logic [3:0]      irq_sts_reg;
    logic [3:0]      irq_msk_reg;
    logic [3:0]      irq_sts_next;
    logic [3:0]      irq_msk_next;
    logic [3:0]      irq_out_reg;
    logic            irq_reg;

    // Clock pins: 0 low-speed, 1 high-speed, 2 external a, 3 external b
    qtm_pin_sync #(
        .N (4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_pin      ({i_ext_clock_pin_b, i_ext_clock_pin_a, i_high_speed_osc_clock, i_low_speed_base_clock}),
        .o_rise     (rise)
    );

    // Bus: one address phase, one wait cycle, then the answer
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg     <= QTM_BUS_IDLE;
            hready_reg <= 1'b1;
            aw_reg     <= 1'b0;
            amap_reg   <= 1'b0;
            aidx_reg   <= 8'h00;
        end else begin
            case (st_reg)
                QTM_BUS_IDLE: begin
                    if (i_hsel && i_htrans[1] && i_hready) begin
                        st_reg     <= QTM_BUS_DATA;
                        hready_reg <= 1'b0;
                        aw_reg     <= i_hwrite;
                        amap_reg   <= (i_haddr[31:10] == 22'h0) && (i_haddr[1:0] == 2'h0);
                        aidx_reg   <= i_haddr[9:2];
                    end
                end
                QTM_BUS_DATA: begin
                    st_reg     <= QTM_BUS_IDLE;
                    hready_reg <= 1'b1;
                end
                default: begin
                    st_reg     <= QTM_BUS_IDLE;
                    hready_reg <= 1'b1;
                end
            endcase
        end
    end

    assign wr_hit = (st_reg == QTM_BUS_DATA) && aw_reg && amap_reg;
    assign rd_hit = (st_reg == QTM_BUS_DATA) && !aw_reg;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hrdata_reg <= 32'h0;
        end else if (rd_hit) begin
            hrdata_reg <= amap_reg ? rd_mux : 32'h0;
        end
    end

    // Register read mux; unmapped and reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0;
        for (int i = 0; i < QTM_NTIM; i++) begin
            if (aidx_reg == QTM_IDX_CNT_LO[i]) rd_mux[3:0] = count[i][3:0];
            if (aidx_reg == QTM_IDX_CNT_HI[i]) rd_mux[3:0] = count[i][7:4];
            if (aidx_reg == QTM_IDX_DAT_LO[i]) rd_mux[3:0] = data[i][3:0];
            if (aidx_reg == QTM_IDX_DAT_HI[i]) rd_mux[3:0] = data[i][7:4];
            if (aidx_reg == QTM_IDX_CON0[i]) rd_mux[2:0] = ctrl_reg[i].mode;
            if (aidx_reg == QTM_IDX_CON1[i]) rd_mux[1:0] = ctrl_reg[i].clk_sel;
            if (aidx_reg == QTM_IDX_STAT[i]) rd_mux[QTM_OVF_BIT] = flag[i];
        end
        if (aidx_reg == QTM_IDX_IRQ_STS) rd_mux[3:0] = irq_sts_reg;
        if (aidx_reg == QTM_IDX_IRQ_MSK) rd_mux[3:0] = irq_msk_reg;
    end

    // Per-timer write strobes
    always_comb begin
        for (int i = 0; i < QTM_NTIM; i++) begin
            wr[i].wdata  = i_hwdata[3:0];
            wr[i].cnt_we = {wr_hit && (aidx_reg == QTM_IDX_CNT_HI[i]),
                            wr_hit && (aidx_reg == QTM_IDX_CNT_LO[i])};
            wr[i].dat_we = {wr_hit && (aidx_reg == QTM_IDX_DAT_HI[i]),
                            wr_hit && (aidx_reg == QTM_IDX_DAT_LO[i])};
        end
    end

    // Mode and clock-select registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < QTM_NTIM; i++) begin
                ctrl_reg[i].mode    <= QTM_CON0_RST;
                ctrl_reg[i].clk_sel <= QTM_CON1_RST;
            end
        end else begin
            for (int i = 0; i < QTM_NTIM; i++) begin
                if (wr_hit && (aidx_reg == QTM_IDX_CON0[i])) begin
                    ctrl_reg[i].mode <= i_hwdata[2:0] & QTM_CON0_MASK[i];
                end
                if (wr_hit && (aidx_reg == QTM_IDX_CON1[i])) begin
                    ctrl_reg[i].clk_sel <= i_hwdata[1:0];
                end
            end
        end
    end

    function automatic logic pick_src(input logic [1:0] sel, input logic ext, input logic partner);
        logic s;
        s = 1'b0;
        case (sel)
            QTM_CLK_LOW:  s = rise[0];
            QTM_CLK_HIGH: s = rise[1];
            QTM_CLK_EXT:  s = ext;
            default:      s = partner;
        endcase
        return s;
    endfunction

    // Clock selection and run enables
    always_comb begin
        tick[0] = pick_src(ctrl_reg[0].clk_sel, rise[2], 1'b0);
        tick[1] = pick_src(ctrl_reg[1].clk_sel, rise[3], ovf[0]);
        tick[2] = pick_src(ctrl_reg[2].clk_sel, rise[2], 1'b0);
        tick[3] = pick_src(ctrl_reg[3].clk_sel, rise[3], ovf[2]);
        en[0] = (ctrl_reg[0].mode == QTM_T0_AR_RUN) || (ctrl_reg[0].mode == QTM_T0_CAP_RUN)
                || (ctrl_reg[0].mode == QTM_T0_FMEAS);
        en[1] = ctrl_reg[1].mode[QTM_RUN_BIT] || (ctrl_reg[1].clk_sel == QTM_CLK_PARTNER);
        en[2] = ctrl_reg[2].mode[QTM_RUN_BIT] || ctrl_reg[2].mode[QTM_FM_BIT];
        en[3] = ctrl_reg[3].mode[QTM_RUN_BIT] || (ctrl_reg[3].clk_sel == QTM_CLK_PARTNER);
    end

    genvar g;
    generate
        for (g = 0; g < QTM_NTIM; g++) begin : g_tim
            qtm_timer_chan u_chan (
                .i_core_clk (i_core_clk),
                .i_nrst     (i_nrst),
                .i_tick     (tick[g] && en[g]),
                .i_wr       (wr[g]),
                .o_count    (count[g]),
                .o_data     (data[g]),
                .o_ovf      (ovf[g]),
                .o_ovf_flag (flag[g])
            );
        end
    endgenerate

    // Overflow interrupt: set wins over write-one-to-clear
    always_comb begin
        irq_sts_next = irq_sts_reg;
        irq_msk_next = irq_msk_reg;
        if (wr_hit && (aidx_reg == QTM_IDX_IRQ_STS)) irq_sts_next = irq_sts_reg & ~i_hwdata[3:0];
        if (wr_hit && (aidx_reg == QTM_IDX_IRQ_MSK)) irq_msk_next = i_hwdata[3:0];
        irq_sts_next = irq_sts_next | ovf;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_sts_reg <= QTM_IRQ_RST;
            irq_msk_reg <= QTM_IRQ_RST;
            irq_reg     <= 1'b0;
        end else begin
            irq_sts_reg <= irq_sts_next;
            irq_msk_reg <= irq_msk_next;
            irq_reg     <= |(irq_sts_next & irq_msk_next);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_out_reg <= 4'h0;
        end else begin
            irq_out_reg <= flag ^ ovf;
        end
    end

    assign o_hrdata     = hrdata_reg;
    assign o_hreadyout  = hready_reg;
    assign o_hresp      = 1'b0;
    assign o_ovf_toggle = irq_out_reg;
    assign o_irq        = irq_reg;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_addr_phase;
        i_hsel && i_htrans[1] && o_hreadyout;
    endsequence

    sequence s_one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    property p_bus_one_wait;
        s_addr_phase |=> s_one_wait;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer not after one wait");

    property p_ctrl_reset;
        !$past(i_nrst) |-> (ctrl_reg[0] == '0) && (ctrl_reg[1] == '0) && (ctrl_reg[2] == '0) && (ctrl_reg[3] == '0);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero after reset");

    property p_cnt_write_data;
        wr[0].cnt_we[0] |=> data[0][3:0] == $past(i_hwdata[3:0]);
    endproperty
    a_cnt_write_data: assert property (p_cnt_write_data) else $error("counter write missed data");

    property p_dat_write_keeps_cnt;
        wr[0].dat_we[0] && !(tick[0] && en[0]) |=> $stable(count[0]);
    endproperty
    a_dat_write_keeps_cnt: assert property (p_dat_write_keeps_cnt) else $error("data write moved count");

    property p_t0_unused_stops;
        ctrl_reg[0].mode > QTM_T0_FMEAS |-> !en[0];
    endproperty
    a_t0_unused_stops: assert property (p_t0_unused_stops) else $error("unused mode counts");

    property p_mode_masks;
        !ctrl_reg[1].mode[2] && !ctrl_reg[2].mode[1] && (ctrl_reg[3].mode[2:1] == 2'h0);
    endproperty
    a_mode_masks: assert property (p_mode_masks) else $error("unimplemented mode bit set");

    property p_t0_ext_clock;
        ctrl_reg[0].clk_sel == QTM_CLK_EXT |-> tick[0] == rise[2];
    endproperty
    a_t0_ext_clock: assert property (p_t0_ext_clock) else $error("timer 0 pin clock wrong");

    property p_t2_no_partner;
        ctrl_reg[2].clk_sel == QTM_CLK_PARTNER |-> !tick[2];
    endproperty
    a_t2_no_partner: assert property (p_t2_no_partner) else $error("timer 2 got partner clock");

    property p_partner_clock;
        (ctrl_reg[1].clk_sel != QTM_CLK_PARTNER || tick[1] == ovf[0])
        && (ctrl_reg[3].clk_sel != QTM_CLK_PARTNER || tick[3] == ovf[2]);
    endproperty
    a_partner_clock: assert property (p_partner_clock) else $error("cascade clock wrong");

    property p_cascade_step;
        ovf[0] && (ctrl_reg[1].clk_sel == QTM_CLK_PARTNER) && (wr[1].cnt_we == 2'h0) && (count[1] != QTM_CNT_MAX)
        |=> count[1] == $past(count[1]) + 8'h01;
    endproperty
    a_cascade_step: assert property (p_cascade_step) else $error("upper timer missed a step");

    property p_count_inc;
        tick[3] && en[3] && (wr[3].cnt_we == 2'h0) && (count[3] != QTM_CNT_MAX)
        |=> count[3] == $past(count[3]) + 8'h01;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("counter did not increment");

    property p_ovf_toggle;
        ovf[2] |=> ##1 o_ovf_toggle[2] != $past(o_ovf_toggle[2], 2);
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle) else $error("overflow flag did not toggle");

    property p_irq_level;
        (irq_sts_reg & irq_msk_reg) != 4'h0 |-> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt low while pending");

    property p_t1_low_clock;
        ctrl_reg[1].clk_sel == QTM_CLK_LOW |-> tick[1] == rise[0];
    endproperty
    a_t1_low_clock: assert property (p_t1_low_clock) else $error("timer 1 low clock wrong");

    property p_t3_high_clock;
        ctrl_reg[3].clk_sel == QTM_CLK_HIGH |-> tick[3] == rise[1];
    endproperty
    a_t3_high_clock: assert property (p_t3_high_clock) else $error("timer 3 high clock wrong");

    property p_t3_stopped;
        !ctrl_reg[3].mode[QTM_RUN_BIT] && (ctrl_reg[3].clk_sel != QTM_CLK_PARTNER) |-> !en[3];
    endproperty
    a_t3_stopped: assert property (p_t3_stopped) else $error("stopped timer 3 enabled");

    property p_t2_freq_runs;
        ctrl_reg[2].mode[QTM_FM_BIT] |-> en[2];
    endproperty
    a_t2_freq_runs: assert property (p_t2_freq_runs) else $error("timer 2 frequency mode idle");

    property p_flag_reset;
        !$past(i_nrst) |-> (flag == 4'h0) && (o_ovf_toggle == 4'h0);
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("overflow flags not zero after reset");

    property p_flag_holds;
        !ovf[1] |=> flag[1] == $past(flag[1]);
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag moved without overflow");

    property p_ovf_reload;
        ovf[1] |=> count[1] == $past(data[1]);
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("overflow did not reload");

    property p_irq_set_wins;
        ovf != 4'h0 |=> (irq_sts_reg & $past(ovf)) == $past(ovf);
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("overflow did not set status");

    property p_stat_reads_flag;
        rd_hit && amap_reg && (aidx_reg == QTM_IDX_STAT[1]) |=> o_hrdata == {31'h0, $past(flag[1])};
    endproperty
    a_stat_reads_flag: assert property (p_stat_reads_flag) else $error("status read wrong");
endmodule

// ---- testbench/qtm_top_tb.sv ----
// Self-checking bench for the quad timer: registers, counting, cascade, interrupt
`timescale 1ns/1ps
module qtm_top_tb;
    import qtm_pkg::*;
    logic        core_clk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [3:0]  clk_src;
    logic [3:0]  ovf_toggle;
    logic        irq;
    int          miscompares;
    int          checked;
    int          cycles;
    int          n;
    integer      seed;
    logic [31:0] rdv;
    logic [7:0]  v8;

    qtm_top dut (
        .i_core_clk(core_clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_low_speed_base_clock(clk_src[0]),
        .i_high_speed_osc_clock(clk_src[1]), .i_ext_clock_pin_a(clk_src[2]),
        .i_ext_clock_pin_b(clk_src[3]), .o_ovf_toggle(ovf_toggle), .o_irq(irq)
    );

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Ceiling is about ten times the expected run of some 2000 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("MISMATCH timeout expected finish seen hang");
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; read data lands in rdv
    task automatic bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr_en;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, {22'h0, idx, 2'h0}, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, {22'h0, idx, 2'h0}, 32'h0);
        chk(what, exp, rdv);
    endtask

    task automatic chk_cnt(input int t, input logic [7:0] exp);
        rd(QTM_IDX_CNT_LO[t], {28'h0, exp[3:0]}, "count low");
        rd(QTM_IDX_CNT_HI[t], {28'h0, exp[7:4]}, "count high");
    endtask

    task automatic pulse(input int src, input int cnt);
        repeat (cnt) begin
            @(posedge core_clk);
            clk_src[src] <= 1'b1;
            repeat (4) @(posedge core_clk);
            clk_src[src] <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        repeat (8) @(posedge core_clk);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
    endtask

    // Implemented mode bits of each timer
    function automatic logic [31:0] mode_exp(input int t, input logic [3:0] v);
        case (t)
            0: mode_exp = {29'h0, v[2:0]};
            1: mode_exp = {30'h0, v[1:0]};
            2: mode_exp = {29'h0, v[2], 1'b0, v[0]};
            default: mode_exp = {31'h0, v[0]};
        endcase
    endfunction

    initial begin
        seed = 32'h60c8;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        clk_src = 4'h0;
        do_reset();
        for (int t = 0; t < QTM_NTIM; t++) begin
            for (int v = 0; v < 16; v++) begin
                wr(QTM_IDX_CON0[t], v);
                rd(QTM_IDX_CON0[t], mode_exp(t, v[3:0]), "mode");
                wr(QTM_IDX_CON1[t], v);
                rd(QTM_IDX_CON1[t], {30'h0, v[1:0]}, "clock select");
            end
            wr(QTM_IDX_CON0[t], 0);
            wr(QTM_IDX_CON1[t], 0);
        end
        $display("test mode and clock registers done");
        // Timer 0 counts from low, high and pin a clocks, one running mode each (1, 3, 4)
        // The oscillator model has no start-up, so its settling wait is already over
        for (int k = 0; k < 3; k++) begin
            v8 = 8'($random(seed));
            v8[7] = 1'b0;
            n = 1 + ($random(seed) & 3);
            wr(QTM_IDX_CON1[0], k);
            wr(QTM_IDX_CNT_LO[0], {28'h0, v8[3:0]});
            wr(QTM_IDX_CNT_HI[0], {28'h0, v8[7:4]});
            wr(QTM_IDX_CON0[0], (k == 0) ? 1 : (k == 1) ? 3 : 4);
            pulse(k, n);
            wr(QTM_IDX_CON0[0], 0);
            chk_cnt(0, v8 + n[7:0]);
            rd(QTM_IDX_DAT_LO[0], {28'h0, v8[3:0]}, "data low");
            rd(QTM_IDX_DAT_HI[0], {28'h0, v8[7:4]}, "data high");
            wr(QTM_IDX_DAT_LO[0], {28'h0, ~v8[3:0]});
            chk_cnt(0, v8 + n[7:0]);
        end
        $display("test counting done");
        // Timer 1 overflows from pin b, reloads, raises masked interrupt
        wr(QTM_IDX_CNT_LO[1], 32'he);
        wr(QTM_IDX_CNT_HI[1], 32'hf);
        wr(QTM_IDX_DAT_LO[1], 32'h5);
        wr(QTM_IDX_DAT_HI[1], 32'h3);
        wr(QTM_IDX_CON1[1], 2);
        wr(QTM_IDX_CON0[1], 1);
        pulse(3, 2);
        wr(QTM_IDX_CON0[1], 0);
        chk_cnt(1, 8'h35);
        rd(QTM_IDX_STAT[1], 32'h1, "overflow flag");
        chk("overflow pin", 32'h2, {28'h0, ovf_toggle});
        rd(QTM_IDX_IRQ_STS, 32'h2, "irq status");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(QTM_IDX_IRQ_MSK, 2);
        repeat (3) @(posedge core_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(QTM_IDX_IRQ_STS, 2);
        repeat (3) @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(QTM_IDX_IRQ_STS, 32'h0, "irq status cleared");
        wr(QTM_IDX_IRQ_MSK, 0);
        $display("test overflow and interrupt done");
        // Pairs 0/1 and 2/3 as 16-bit timers; lower reloads ff so every tick overflows
        for (int p = 0; p < 2; p++) begin
            n = 1 + ($random(seed) & 3);
            wr(QTM_IDX_CON1[2*p+1], 3);
            wr(QTM_IDX_CNT_LO[2*p+1], 0);
            wr(QTM_IDX_CNT_HI[2*p+1], 0);
            wr(QTM_IDX_CNT_LO[2*p], 32'hf);
            wr(QTM_IDX_CNT_HI[2*p], 32'hf);
            wr(QTM_IDX_CON1[2*p], 2);
            wr(QTM_IDX_CON0[2*p], 1);
            pulse(2, n);
            wr(QTM_IDX_CON0[2*p], 0);
            wr(QTM_IDX_CON1[2*p+1], 0);
            chk_cnt(2*p+1, n[7:0]);
            rd(QTM_IDX_STAT[2*p], {31'h0, n[0]}, "lower overflow flag");
            chk("lower overflow pin", {31'h0, n[0]}, {31'h0, ovf_toggle[2*p]});
        end
        $display("test cascade done");
        // Out-of-range address and read-only status; timer 3 keeps its cascade count
        bus(1'b1, {22'h1, QTM_IDX_CNT_LO[3], 2'h0}, 32'h5);
        chk_cnt(3, n[7:0]);
        bus(1'b0, {22'h1, QTM_IDX_CNT_LO[3], 2'h0}, 32'h0);
        chk("unmapped read", 32'h0, rdv);
        chk("unmapped response", 32'h0, {31'h0, hresp});
        wr(QTM_IDX_STAT[3], 1);
        rd(QTM_IDX_STAT[3], 32'h0, "status read only");
        $display("test unmapped done");
        wr(QTM_IDX_CON0[0], 3);
        wr(QTM_IDX_CON1[3], 3);
        do_reset();
        for (int t = 0; t < QTM_NTIM; t++) begin
            rd(QTM_IDX_CON0[t], 32'h0, "mode after reset");
            rd(QTM_IDX_CON1[t], 32'h0, "clock after reset");
            rd(QTM_IDX_STAT[t], 32'h0, "status after reset");
            chk_cnt(t, 8'h00);
        end
        chk("overflow pins after reset", 32'h0, {28'h0, ovf_toggle});
        $display("test reset done");
        end_sim();
    end
endmodule
